/* rtl/olsr_pkg.sv */
// Package for the open-load status register bank.
// Assumes a single 20 MHz system clock domain shared by all users.
package olsr_pkg;
	localparam int OLSR_BRIDGES = 12;
	localparam int OLSR_REG_W = 8;
	localparam int OLSR_NREGS = 3;
	// Register select codes on the read strobe (address field of the command byte)
	localparam logic [4:0] OLSR_ADDR_B1_4 = 5'h01;  // 000 01
	localparam logic [4:0] OLSR_ADDR_B5_8 = 5'h11;  // 100 01
	localparam logic [4:0] OLSR_ADDR_B9_12 = 5'h09; // Chosen for third bank
	localparam logic [7:0] OLSR_RESET_VAL = 8'h00;
	localparam int OLSR_LOW_BIT = 0;
	localparam int OLSR_HIGH_BIT = 1;

	typedef struct packed {
		logic rd;
		logic [4:0] addr;
	} olsr_rd_req_t;

	typedef struct packed {
		logic [11:0] high;
		logic [11:0] low;
	} olsr_detect_t;
endpackage : olsr_pkg

/* rtl/olsr_regs.sv */
// Open-load status registers, three 8-bit read-to-clear banks.
// Assumes the read strobe comes from logic on mclk; detector flags may be
// asynchronous and are synchronised here.
//
// Operation
// (R1) Register 0: bridges 1-4, bit7 bridge4 high down to bit0 bridge1 low.
// (R2) Register 1: bridges 5-8, bit7 bridge8 high down to bit0 bridge5 low.
// (R3) Register 2: bridges 9-12, bit7 bridge12 high down to bit0 bridge9 low.
// (R4) Even bit is low-side switch, odd bit high-side, same bridge.
// (R5) A detected open load sets its bit and latches it.
// (R6) All status bits are zero after reset.
// (R7) Reading returns the latched value, then clears the register.
// (R8) Host selects bank one with 000 01 and bank two with 100 01.
// (R9) Detection coinciding with the clearing read keeps the bit set.
`timescale 1ns/1ns
module olsr_regs
	import olsr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire olsr_detect_t detect,
	input wire olsr_rd_req_t rd_req,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	logic [OLSR_NREGS-1:0][OLSR_REG_W-1:0] stat_r, stat_nxt;
	logic [OLSR_REG_W-1:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [OLSR_NREGS-1:0] sel;
	logic [OLSR_NREGS-1:0][OLSR_REG_W-1:0] set_vec;
	// Synchroniser stages for the detector flags
	olsr_detect_t det_meta_r, det_meta_nxt;
	olsr_detect_t det_sync_r, det_sync_nxt;

	always_comb begin
		sel = '0;
		if (rd_req.rd) begin
			case (rd_req.addr) // [R8]
				OLSR_ADDR_B1_4: sel[0] = 1'b1;
				OLSR_ADDR_B5_8: sel[1] = 1'b1;
				OLSR_ADDR_B9_12: sel[2] = 1'b1;
				default: sel = '0;
			endcase
		end
	end

	// Flags come from analog comparators,
	// so two flip-flops stand before any logic.
	// Limitation: a flag shorter than one mclk may be missed.
	always_comb begin
		det_meta_nxt = detect;
		det_sync_nxt = det_meta_r;
	end

	// Two cycles of latency, harmless for a latched bit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			det_meta_r <= '0;
			det_sync_r <= '0;
		end else begin
			det_meta_r <= det_meta_nxt;
			det_sync_r <= det_sync_nxt;
		end
	end

	// Two bits per bridge, four bridges per bank
	always_comb begin
		set_vec = '0;
		for (int b = 0; b < OLSR_BRIDGES; b++) begin
			set_vec[b/4][(b%4)*2+OLSR_LOW_BIT] = det_sync_r.low[b];   // [R1] [R2] [R3] [R4]
			set_vec[b/4][(b%4)*2+OLSR_HIGH_BIT] = det_sync_r.high[b]; // [R4]
		end
	end

	always_comb begin
		stat_nxt = stat_r;
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = rd_req.rd;
		for (int i = 0; i < OLSR_NREGS; i++) begin
			if (sel[i]) begin
				rd_data_nxt = stat_r[i];        // [R7]
				stat_nxt[i] = OLSR_RESET_VAL;   // [R7]
			end
			// Set after clear so a coincident event survives
			stat_nxt[i] = stat_nxt[i] | set_vec[i]; // [R5] [R9]
		end
		// Unmapped select reads zero
		if (rd_req.rd && sel == '0) begin
			rd_data_nxt = OLSR_RESET_VAL;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stat_r <= {OLSR_NREGS{OLSR_RESET_VAL}}; // [R6]
			rd_data_r <= OLSR_RESET_VAL;
			rd_valid_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Checks are silent while reset is held
	reset_zero_a: assert property ($rose(rst_n) |-> stat_r == '0) // [R6]
		else $error("status not zero after reset");
	reset_out_a: assert property ( // [R6]
		$rose(rst_n)
		|-> rd_data == OLSR_RESET_VAL && !rd_valid)
		else $error("read port not idle after reset");
	valid_pulse_a: assert property ( // [R7]
		rd_req.rd
		|=> rd_valid)
		else $error("read strobe not answered");
	valid_idle_a: assert property ( // [R7]
		!rd_req.rd
		|=> !rd_valid)
		else $error("answer without a read strobe");
	data_hold_a: assert property ( // [R7]
		!rd_req.rd
		|=> $stable(rd_data))
		else $error("read data changed without a read");

	// Latching and bit placement, on the synchronised flags
	latch_set_a: assert property (det_sync_r.low[0] |=> stat_r[0][0]) // [R5]
		else $error("bridge1 low detect not latched");
	hold_bit_a: assert property (stat_r[1][7] && !sel[1] |=> stat_r[1][7]) // [R5]
		else $error("latched bit dropped without read");
	hold_b3_a: assert property ( // [R5]
		stat_r[2][0] && !sel[2]
		|=> stat_r[2][0])
		else $error("bank three bit dropped without read");
	no_spont_a: assert property ( // [R5]
		!stat_r[0][0] && !det_sync_r.low[0]
		|=> !stat_r[0][0])
		else $error("bit set with no detection");
	no_spont_b3_a: assert property ( // [R5]
		!stat_r[2][7] && !det_sync_r.high[11]
		|=> !stat_r[2][7])
		else $error("bank three bit set with no detection");
	map_b1_a: assert property ( // [R1]
		det_sync_r.high[0]
		|=> stat_r[0][1])
		else $error("bridge1 high not at bit 1");
	map_b3_a: assert property ( // [R1]
		det_sync_r.low[2]
		|=> stat_r[0][4])
		else $error("bridge3 low not at bit 4");
	map_b4_a: assert property (det_sync_r.high[3] |=> stat_r[0][7]) // [R1]
		else $error("bridge4 high not at bit 7");
	map_b5_a: assert property (det_sync_r.low[4] |=> stat_r[1][0]) // [R2]
		else $error("bridge5 low not at bit 0");
	map_b7_a: assert property ( // [R2]
		det_sync_r.low[6]
		|=> stat_r[1][4])
		else $error("bridge7 low not at bit 4");
	map_b8_a: assert property ( // [R2]
		det_sync_r.high[7]
		|=> stat_r[1][7])
		else $error("bridge8 high not at bit 7");
	map_b10_a: assert property ( // [R3]
		det_sync_r.high[9]
		|=> stat_r[2][3])
		else $error("bridge10 high not at bit 3");
	map_b12_a: assert property ( // [R3]
		det_sync_r.low[11]
		|=> stat_r[2][6])
		else $error("bridge12 low not at bit 6");
	high_map_a: assert property (det_sync_r.high[11] |=> stat_r[2][7]) // [R3]
		else $error("bridge12 high not at bit 7");
	odd_high_a: assert property ( // [R4]
		det_sync_r.high[0] && !det_sync_r.low[0] && stat_r[0][0] == 1'b0 && !sel[0]
		|=> stat_r[0][1:0] == 2'b10)
		else $error("high side not on odd bit");
	even_low_a: assert property ( // [R4]
		det_sync_r.low[5] && !det_sync_r.high[5] && stat_r[1][3] == 1'b0 && !sel[1]
		|=> stat_r[1][3:2] == 2'b01)
		else $error("low side not on even bit");

	// Read to clear; codes that select nothing read zero and clear nothing
	rd_clear_a: assert property ( // [R7]
		sel[0] && set_vec[0] == '0
		|=> stat_r[0] == '0 && rd_data == $past(stat_r[0]) && rd_valid)
		else $error("read did not return and clear");
	clear_b2_a: assert property ( // [R7]
		sel[1] && set_vec[1] == '0
		|=> stat_r[1] == '0 && rd_data == $past(stat_r[1]))
		else $error("bank two read did not return and clear");
	clear_b3_a: assert property ( // [R7]
		sel[2] && set_vec[2] == '0
		|=> stat_r[2] == '0 && rd_data == $past(stat_r[2]))
		else $error("bank three read did not return and clear");
	unmap_keep_a: assert property ( // [R7]
		rd_req.rd && sel == '0 && set_vec == '0
		|=> rd_data == OLSR_RESET_VAL && stat_r == $past(stat_r))
		else $error("unmapped read cleared or returned data");

	// Set wins over a clearing read in the same cycle
	set_wins_a: assert property (sel[2] && det_sync_r.low[8] |=> stat_r[2][0]) // [R9]
		else $error("coincident event lost");
	set_wins_b1_a: assert property ( // [R9]
		sel[0] && det_sync_r.low[2]
		|=> stat_r[0][4])
		else $error("bank one coincident event lost");
	sel_code_a: assert property (rd_req.rd && rd_req.addr == OLSR_ADDR_B5_8 |-> sel == 3'b010) // [R8]
		else $error("bank two select code wrong");

	// Main scenarios
	read_b1_c: cover property (sel[0] && stat_r[0] != '0);
	read_b2_c: cover property (sel[1] && stat_r[1] != '0);
	read_b3_c: cover property (sel[2] && stat_r[2] != '0);
	collide_c: cover property (sel[1] && set_vec[1] != '0);
	unmap_c: cover property (rd_req.rd && sel == '0);
endmodule : olsr_regs

/* tb/olsr_host.sv */
// Host model issuing register reads.
// Assumes the answer comes one clock after the strobe.
`timescale 1ns/1ns
module olsr_host
	import olsr_pkg::*;
(
	input wire logic mclk,
	output olsr_rd_req_t rd_req,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	initial rd_req = '0;
	task automatic rd(input logic [4:0] addr, output logic [7:0] data);
		@(posedge mclk) #1 rd_req = '{rd: 1'b1, addr: addr};
		@(posedge mclk) #1 rd_req = '0;
		data = rd_valid ? rd_data : 8'hxx;
	endtask : rd
endmodule : olsr_host

/* tb/olsr_regs_tb.sv */
// Testbench for the open-load status bank.
// Assumes the host model and a 20 MHz clock.
`timescale 1ns/1ns
module olsr_regs_tb;
	import olsr_pkg::*;
	logic mclk = 0;
	logic rst_n = 0;
	olsr_detect_t detect = '0;
	olsr_rd_req_t rd_req;
	logic [7:0] rd_data, v;
	logic rd_valid;
	int fails = 0, total_checks = 0, cyc = 0;
	localparam logic [4:0] ADDR [3] = '{OLSR_ADDR_B1_4, OLSR_ADDR_B5_8, OLSR_ADDR_B9_12};
	// Code that selects no register
	localparam logic [4:0] ADDR_NONE = 5'h1f;
	olsr_regs dut_u (.mclk(mclk), .rst_n(rst_n), .detect(detect), .rd_req(rd_req), .rd_data(rd_data),
		.rd_valid(rd_valid));
	olsr_host host_u (.mclk(mclk), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));
	initial forever #25 mclk = ~mclk;
	task automatic check(input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic t_reset;
		for (int i = 0; i < 3; i++) begin
			host_u.rd(ADDR[i], v);
			check(v, OLSR_RESET_VAL);
		end
		$display("reset test done");
	endtask : t_reset
	task automatic t_map;
		for (int b = 0; b < 12; b++) begin
			for (int s = 0; s < 2; s++) begin
				@(posedge mclk) #1 detect = '{high: 12'(s) << b, low: 12'(1 - s) << b};
				@(posedge mclk) #1 detect = '0;
				// Idle gap proves the bit latched
				repeat (4) @(posedge mclk);
				host_u.rd(ADDR[b / 4], v);
				check(v, 8'h01 << (2 * (b % 4) + s));
				host_u.rd(ADDR[b / 4], v);
				check(v, 8'h00);
			end
		end
		$display("map test done");
	endtask : t_map
	task automatic t_coin;
		int b;
		for (int k = 0; k < 3; k++) begin
			b = 3 * k + 2;
			@(posedge mclk) #1 detect.high[b] = 1'b1;
			@(posedge mclk) #1 detect = '0;
			repeat (4) @(posedge mclk);
			// Low side reaches the bank through the synchroniser on the read edge
			fork
				begin
					repeat (2) @(posedge mclk);
					host_u.rd(ADDR[k], v);
				end
				begin
					@(posedge mclk) #1 detect.low[b] = 1'b1;
					@(posedge mclk) #1 detect = '0;
				end
			join
			check(v, 8'h02 << (2 * (b % 4)));
			host_u.rd(ADDR[k], v);
			check(v, 8'h01 << (2 * (b % 4)));
		end
		$display("coincide test done");
	endtask : t_coin
	task automatic t_unmap;
		@(posedge mclk) #1 detect.high[4] = 1'b1;
		@(posedge mclk) #1 detect = '0;
		repeat (4) @(posedge mclk);
		host_u.rd(ADDR_NONE, v);
		check(v, 8'h00);
		host_u.rd(ADDR[1], v);
		check(v, 8'h02);
		$display("unmapped test done");
	endtask : t_unmap
	task automatic t_rerst;
		@(posedge mclk) #1 detect = '{high: 12'hfff, low: 12'hfff};
		@(posedge mclk) #1 detect = '0;
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 3; i++) begin
			host_u.rd(ADDR[i], v);
			check(v, OLSR_RESET_VAL);
		end
		$display("mid-run reset test done");
	endtask : t_rerst
	// Whole run needs a few hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 2000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		#1 rst_n = 1;
		t_reset();
		t_map();
		t_coin();
		t_unmap();
		t_rerst();
		close_out();
	end
endmodule : olsr_regs_tb
